// ### bench/ingress_monitor_bench.sv
// Self-checking bench for the ingress monitor
module ingress_monitor_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import ingress_pkg::*;
	logic             core_clk, arst_n, xpdr_fitted, key_valid, cfg_we;
	logic             cfg_port, meas_req, meas_port, meas_digital, meas_valid;
	logic [IDX_W-1:0] cfg_idx, meas_idx, list_len [2];
	logic [CNT_W-1:0] tolerance;
	logic [LVL_W-1:0] meas_level, base [2][30];
	logic [1:0]       ingress_alarm, ingress_warning;
	entry_t           cfg_entry, ent [2][30];
	blk_mode_t        auto_ingress_block [2];
	logic [DLY_W-1:0] act_delay [2], deact_delay [2];
	logic [3:0]       atten_cfg [2];
	switch_t          user_switch [2], switch_out [2];
	bit               wa [2][30], aa [2][30], ea [2], ew [2];
	int               err_count = 0, compares = 0, cyc = 0;
	ingress_monitor ingress_monitor_inst (.core_clk, .arst_n, .xpdr_fitted,
		.key_valid, .cfg_we, .cfg_port, .cfg_idx, .cfg_entry, .list_len,
		.tolerance, .meas_req, .meas_port, .meas_idx, .meas_digital,
		.meas_valid, .meas_level, .ingress_alarm, .ingress_warning,
		.auto_ingress_block, .act_delay, .deact_delay, .atten_cfg,
		.user_switch, .switch_out);
	meas_receiver_model meas_receiver_model_inst (.core_clk, .meas_req,
		.meas_port, .meas_idx, .meas_digital, .xpdr_fitted, .base,
		.meas_valid, .meas_level);
	always #4 core_clk = ~core_clk;
	// Hang guard well above the expected run
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			err_count++;
			finish_test();
		end
	end
	// ==========================================================
	// Tasks
	task automatic chk(string n, logic [7:0] e, logic [7:0] s);
		compares++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// A write also clears that entry's exceedances
	task automatic wr(int p, int i);
		@(negedge core_clk);
		cfg_we = 1'b1;
		cfg_port = 1'(p);
		cfg_idx = IDX_W'(i);
		cfg_entry = ent[p][i];
		wa[p][i] = 0;
		aa[p][i] = 0;
		@(negedge core_clk);
		cfg_we = 1'b0;
	endtask
	// Reference pass with 1 dB hold on active limits
	task automatic ref_pass(int p);
		int wc, ac, l;
		wc = 0;
		ac = 0;
		for (int i = 0; i < list_len[p]; i++) begin
			l = base[p][i];
			wa[p][i] = ent[p][i].warn_en &&
				l + (wa[p][i] ? 10 : 0) > ent[p][i].warn_lim;
			aa[p][i] = ent[p][i].alarm_en &&
				l + (aa[p][i] ? 10 : 0) > ent[p][i].alarm_lim;
			wc += wa[p][i];
			ac += aa[p][i];
		end
		ea[p] = ac > tolerance;
		ew[p] = wc > tolerance && !ea[p];
	endtask
	function automatic switch_t exp_of(int p);
		sw_state_t t;
		t = SW_0DB;
		if (ea[p]) t = (auto_ingress_block[p] == BLK_ALM_ATT) ? SW_ATT : SW_CUT;
		else if (ew[p] && auto_ingress_block[p] == BLK_COMBO) t = SW_ATT;
		if (auto_ingress_block[p] == BLK_OFF) return user_switch[p];
		return '{t, (atten_cfg[p] < ATT_MIN || atten_cfg[p] > ATT_MAX) ?
			ATT_DEF : atten_cfg[p]};
	endfunction
	// One pass over both inputs with fresh levels and settings
	task automatic round(int r);
		int n;
		bit s1;
		@(negedge core_clk);
		tolerance = (r == 0) ? '0 : CNT_W'($urandom % 3);
		for (int p = 0; p < 2; p++) begin
			list_len[p] = (r == 3) ? 5'h1e : IDX_W'(1 + $urandom % 30);
			auto_ingress_block[p] = blk_mode_t'(r < 8 ? (r + p) % 4 : $urandom);
			atten_cfg[p] = 4'($urandom);
			user_switch[p] = '{sw_state_t'($urandom % 3), 4'($urandom)};
			for (int i = 0; i < 30; i++) base[p][i] = 10'(ent[p][i].warn_lim
				- 15 + $urandom % (31 + ent[p][i].alarm_lim - ent[p][i].warn_lim));
		end
		// Single entry just above, just held and just cleared around its limit
		if (r < 3) begin
			list_len[0] = 5'h01;
			base[0][0] = 10'(int'(ent[0][0].alarm_lim) + (r == 0 ? 1 :
				r == 1 ? -9 : -10));
		end
		wr(1, $urandom % 30);
		key_valid = 1'b0;
		xpdr_fitted = 1'b1;
		n = 0;
		repeat (40) begin
			@(negedge core_clk);
			n += meas_req;
		end
		chk("gated requests", 8'h0, 8'(n));
		key_valid = 1'b1;
		s1 = 0;
		for (int c = 0; c < 9000 && !(s1 && meas_req && !meas_port &&
			meas_idx == 0); c++) begin
			@(negedge core_clk);
			s1 |= meas_req & meas_port;
		end
		xpdr_fitted = 1'b0;
		ref_pass(0);
		ref_pass(1);
		repeat (12) @(negedge core_clk);
		for (int p = 0; p < 2; p++) begin
			chk("alarm", 8'(ea[p]), 8'(ingress_alarm[p]));
			chk("warning", 8'(ew[p]), 8'(ingress_warning[p]));
			chk("switch", 8'(exp_of(p)), 8'(switch_out[p]));
		end
		$display("round %0d done", r);
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		core_clk = 1'b0;
		arst_n = 1'b0;
		xpdr_fitted = 1'b0;
		key_valid = 1'b0;
		cfg_we = 1'b0;
		cfg_port = 1'b0;
		cfg_idx = '0;
		cfg_entry = '0;
		tolerance = '0;
		void'($urandom(73665));
		for (int p = 0; p < 2; p++) begin
			list_len[p] = 5'h01;
			auto_ingress_block[p] = BLK_OFF;
			atten_cfg[p] = ATT_DEF;
			user_switch[p] = '0;
			act_delay[p] = DLY_W'(1 + $urandom % 6);
			deact_delay[p] = DLY_W'(1 + $urandom % 6);
			for (int i = 0; i < 30; i++) begin
				ent[p][i] = '{1'($urandom), 1'($urandom),
					10'(400 + $urandom % 200), 1'($urandom), 10'h000};
				ent[p][i].alarm_lim = ent[p][i].warn_lim + 10'($urandom % 60);
				base[p][i] = '0;
			end
		end
		ent[0][0].warn_en = 1'b0;
		ent[0][0].alarm_en = 1'b1;
		repeat (8) @(negedge core_clk);
		arst_n = 1'b1;
		repeat (4) @(negedge core_clk);
		for (int p = 0; p < 2; p++)
			for (int i = 0; i < 30; i++) wr(p, i);
		for (int r = 0; r < 16; r++) round(r);
		finish_test();
	end
endmodule // ingress_monitor_bench
bind ingress_monitor ingress_monitor_checker ingress_monitor_checker_inst (
	.core_clk, .arst_n, .xpdr_fitted, .key_valid, .meas_req, .meas_valid,
	.ingress_alarm, .ingress_warning, .auto_ingress_block, .act_delay,
	.deact_delay, .atten_cfg, .user_switch, .switch_out);

// ### bench/ingress_monitor_checker.sv
// Port-level assertions for the ingress monitor
module ingress_monitor_checker (
	input wire logic                          core_clk,
	input wire logic                          arst_n,
	input wire logic                          xpdr_fitted,
	input wire logic                          key_valid,
	input wire logic                          meas_req,
	input wire logic                          meas_valid,
	input wire logic [1:0]                    ingress_alarm,
	input wire logic [1:0]                    ingress_warning,
	input wire ingress_pkg::blk_mode_t        auto_ingress_block [2],
	input wire logic [ingress_pkg::DLY_W-1:0] act_delay [2],
	input wire logic [ingress_pkg::DLY_W-1:0] deact_delay [2],
	input wire logic [3:0]                    atten_cfg [2],
	input wire ingress_pkg::switch_t          user_switch [2],
	input wire ingress_pkg::switch_t          switch_out [2]
);
	import ingress_pkg::*;
	logic [1:0] up_ff;        // Edges since reset release
	logic       live;         // Internal reset copy surely gone
	logic [3:0] prv_ff [2];   // Last status and mode
	logic [7:0] stab_ff [2];  // Cycles that status and mode held
	assign live = (up_ff == 2'h3);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!live);
	// ==========================================================
	// Helper counters
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) up_ff <= 2'h0;
		else if (!live) up_ff <= up_ff + 2'h1;
	end
	// Saturates so long holds never wrap
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			prv_ff <= '{4'h0, 4'h0};
			stab_ff <= '{8'h0, 8'h0};
		end else begin
			for (int i = 0; i < 2; i++) begin
				prv_ff[i] <= {ingress_alarm[i], ingress_warning[i],
					auto_ingress_block[i]};
				if ({ingress_alarm[i], ingress_warning[i],
					auto_ingress_block[i]} != prv_ff[i]) stab_ff[i] <= 8'h0;
				else if (stab_ff[i] != 8'hff) stab_ff[i] <= stab_ff[i] + 8'h1;
			end
		end
	end
	// ==========================================================
	// Per input blocking checks
	for (genvar i = 0; i < 2; i++) begin : g_in
		logic [7:0] dly;  // Delay toward the state now shown
		logic [7:0] tdl;  // Delay toward the target
		sw_state_t  tgt;
		assign dly = 8'((switch_out[i].state == SW_0DB) ?
			deact_delay[i] : act_delay[i]);
		assign tgt = (auto_ingress_block[i] == BLK_COMBO) ?
			(ingress_alarm[i] ? SW_CUT : ingress_warning[i] ? SW_ATT : SW_0DB) :
			!ingress_alarm[i] ? SW_0DB :
			(auto_ingress_block[i] == BLK_ALM_CUT) ? SW_CUT : SW_ATT;
		assign tdl = 8'((tgt == SW_0DB) ? deact_delay[i] : act_delay[i]);
		sequence s_auto;
			auto_ingress_block[i] != BLK_OFF &&
			$past(auto_ingress_block[i], 2) != BLK_OFF;
		endsequence
		chk_off_follow: assert property (
			auto_ingress_block[i] == BLK_OFF |=>
			switch_out[i] == $past(user_switch[i]))
			else $error("switch not following user setting");
		chk_delay_exact: assert property (
			s_auto ##0 $changed(switch_out[i].state) |->
			stab_ff[i] == dly + 8'h1)
			else $error("switch moved off its delay");
		chk_target_reach: assert property (
			s_auto ##0 (stab_ff[i] == tdl + 8'h3) |->
			switch_out[i].state == tgt)
			else $error("switch missed its target");
		chk_atten_sel: assert property (
			s_auto ##0 $stable(atten_cfg[i]) |-> switch_out[i].atten_db ==
			((atten_cfg[i] < ATT_MIN || atten_cfg[i] > ATT_MAX) ?
			ATT_DEF : atten_cfg[i]))
			else $error("attenuation level wrong");
		chk_status_excl: assert property (
			!(ingress_alarm[i] && ingress_warning[i]))
			else $error("warning beside alarm");
	end
	// ==========================================================
	// Measurement sequencing
	chk_status_pass: assert property (
		$changed({ingress_alarm, ingress_warning}) |-> $past(meas_valid, 2))
		else $error("status changed outside pass end");
	chk_req_gated: assert property (
		meas_req |-> xpdr_fitted && key_valid)
		else $error("request without transponder or key");
	chk_req_single: assert property (
		meas_req |=> !meas_req)
		else $error("request longer than one cycle");
endmodule // ingress_monitor_checker

// ### bench/meas_receiver_model.sv
// Behavioural measurement receiver answering each request once
module meas_receiver_model (
	input  wire logic                          core_clk,
	input  wire logic                          meas_req,
	input  wire logic                          meas_port,
	input  wire logic [ingress_pkg::IDX_W-1:0] meas_idx,
	input  wire logic                          meas_digital,
	input  wire logic                          xpdr_fitted,
	input  wire logic [ingress_pkg::LVL_W-1:0] base [2][30],
	output logic                               meas_valid,
	output logic [ingress_pkg::LVL_W-1:0]      meas_level
);
	timeunit 1ns;
	timeprecision 1ns;
	import ingress_pkg::*;
	logic [5:0]       last;  // Entry of the previous request
	int               k;     // Sample number within an analog entry
	int               n;     // Random answer latency
	logic             p;
	logic [IDX_W-1:0] i;
	logic             dg;
	initial begin
		meas_valid = 1'b0;
		meas_level = '0;
		last = '1;
		k = 0;
	end
	// Aborted entries restart their sample count
	always @(negedge xpdr_fitted) last = '1;
	// ==========================================================
	// One answer per request, latency 0 to 3 cycles
	always begin
		@(posedge core_clk iff meas_req === 1'b1);
		p = meas_port;
		i = meas_idx;
		dg = meas_digital;
		if ({p, i} != last) k = 0;
		last = {p, i};
		n = $urandom % 4;
		repeat (n) @(posedge core_clk);
		#1;
		meas_valid = 1'b1;
		// Digital samples and the third analog sample carry the full level
		meas_level = (dg || k == 2) ? base[p][i] :
			base[p][i] - LVL_W'(1 + $urandom % 20);
		k++;
		@(posedge core_clk);
		#1;
		meas_valid = 1'b0;
		// Released data line shows no stale level
		meas_level = ~meas_level;
	end
endmodule // meas_receiver_model

// ### rtl/ingress_monitor.sv
// Ingress analyser sequencer, limit supervision and automatic blocking
// Contract
// - Blocking enabled: device drives switch states itself
// - Blocking disabled: switch follows user setting
// - Alarm modes: delayed attenuate or cut, delayed restore
// - Combined: warning attenuates, alarm cuts, both restore
// - Attenuation 6 dB default, 3 to 10 dB
// - Measure only with transponder fitted and key valid
// - Analog peak of 5, digital averaged
// - Per input list of 30 entries with limits
// - Compare only against limits present
// - Statuses update after full pass via tolerance
// - Tolerance zero: one exceedance raises status
// - Alarm when alarm exceedances exceed tolerance
// - Warning when warning count exceeds, alarm inactive
// - Exceedance clears only 1 dB below limit
// - Switch control per input, measurement unaffected
module ingress_monitor (
	input  wire logic                               core_clk,
	input  wire logic                               arst_n,
	input  wire logic                               xpdr_fitted,
	input  wire logic                               key_valid,
	input  wire logic                               cfg_we,
	input  wire logic                               cfg_port,
	input  wire logic [ingress_pkg::IDX_W-1:0]      cfg_idx,
	input  wire ingress_pkg::entry_t                cfg_entry,
	input  wire logic [ingress_pkg::IDX_W-1:0]      list_len [2],
	input  wire logic [ingress_pkg::CNT_W-1:0]      tolerance,
	output logic                                    meas_req,
	output logic                                    meas_port,
	output logic [ingress_pkg::IDX_W-1:0]           meas_idx,
	output logic                                    meas_digital,
	input  wire logic                               meas_valid,
	input  wire logic [ingress_pkg::LVL_W-1:0]      meas_level,
	output logic [1:0]                              ingress_alarm,
	output logic [1:0]                              ingress_warning,
	input  wire ingress_pkg::blk_mode_t             auto_ingress_block [2],
	input  wire logic [ingress_pkg::DLY_W-1:0]      act_delay [2],
	input  wire logic [ingress_pkg::DLY_W-1:0]      deact_delay [2],
	input  wire logic [3:0]                         atten_cfg [2],
	input  wire ingress_pkg::switch_t               user_switch [2],
	output ingress_pkg::switch_t                    switch_out [2]
);
	import ingress_pkg::*;

	// ==========================================================
	// Reset release
	logic rst_meta_ff;       // First stage, read only by second
	logic rst_sync_ff;       // Released reset for the core
	// Two stages so the release never lands near a clock edge
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// ==========================================================
	// Measurement list storage
	entry_t entry_mem [2][MAX_FREQ];   // Frequency lists per input
	// Lists are written from configuration; no reset needed
	always_ff @(posedge core_clk) begin
		if (cfg_we && cfg_idx < LIST_MAX) begin
			entry_mem[cfg_port][cfg_idx] <= cfg_entry;
		end
	end

	// ==========================================================
	// Scan sequencer
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,   // Waiting to start a pass
		SEQ_REQ  = 2'b01,   // Request one sample
		SEQ_WAIT = 2'b11,   // Awaiting the receiver's result
		SEQ_NEXT = 2'b10    // Advance or close the pass
	} seq_t;

	seq_t                 state_ff;
	logic                 port_ff;       // Input being scanned
	logic [IDX_W-1:0]     idx_ff;        // Entry being measured
	logic [2:0]           samp_ff;       // Samples taken for the entry
	logic [LVL_W-1:0]     peak_ff;       // Max hold so far
	logic [CNT_W-1:0]     warn_cnt_ff;   // Warning exceedances in pass
	logic [CNT_W-1:0]     alarm_cnt_ff;  // Alarm exceedances in pass
	logic                 run;           // Analyser may work
	entry_t               cur;           // Entry under measurement
	logic [IDX_W-1:0      ] cur_len;     // Length of the scanned list
	logic [LVL_W-1:0]     nxt_peak;      // Running maximum
	logic                 take;          // Result accepted
	logic                 final_res;     // Entry result complete
	logic                 last_entry;    // Current entry ends the pass
	logic                 nxt_warn;      // Warning exceedance after result
	logic                 nxt_alarm;     // Alarm exceedance after result
	logic [MAX_FREQ-1:0]  warn_act_ff [2];
	logic [MAX_FREQ-1:0]  alarm_act_ff [2];

	assign run        = xpdr_fitted && key_valid;
	assign cur        = entry_mem[port_ff][idx_ff];
	assign cur_len    = (list_len[port_ff] > LIST_MAX) ? LIST_MAX
	                    : list_len[port_ff];
	assign take       = (state_ff == SEQ_WAIT) && meas_valid;
	assign last_entry = ({1'b0, idx_ff} + 6'h01) >= {1'b0, cur_len};
	// Peak detector keeps the largest of five, digital takes one
	assign nxt_peak   = (samp_ff == 3'h0 || meas_level > peak_ff)
	                    ? meas_level : peak_ff;
	assign final_res  = take && (cur.digital ||
	                    samp_ff == PEAK_SAMPLES - 3'h1);

	// Limit test with 1 dB hysteresis on an active exceedance
	always_comb begin
		nxt_warn  = 1'b0;
		nxt_alarm = 1'b0;
		if (cur.warn_en) begin
			nxt_warn = warn_act_ff[port_ff][idx_ff]
			           ? ({1'b0, nxt_peak} + {1'b0, HYST_LSB} >
			              {1'b0, cur.warn_lim})
			           : (nxt_peak > cur.warn_lim);
		end
		if (cur.alarm_en) begin
			nxt_alarm = alarm_act_ff[port_ff][idx_ff]
			            ? ({1'b0, nxt_peak} + {1'b0, HYST_LSB} >
			               {1'b0, cur.alarm_lim})
			            : (nxt_peak > cur.alarm_lim);
		end
	end

	// Sequencer walks both lists in turn, one pass per input
	always_ff @(posedge core_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			state_ff     <= SEQ_IDLE;
			port_ff      <= 1'b0;
			idx_ff       <= '0;
			samp_ff      <= 3'h0;
			peak_ff      <= '0;
			warn_cnt_ff  <= '0;
			alarm_cnt_ff <= '0;
		end else begin
			unique case (state_ff)
				SEQ_IDLE: begin
					idx_ff       <= '0;
					samp_ff      <= 3'h0;
					warn_cnt_ff  <= '0;
					alarm_cnt_ff <= '0;
					if (run) begin
						state_ff <= (cur_len == '0) ? SEQ_NEXT : SEQ_REQ;
					end
				end
				SEQ_REQ: begin
					state_ff <= run ? SEQ_WAIT : SEQ_IDLE;
				end
				// Outstanding request is always seen to its result
				SEQ_WAIT: begin
					if (take) begin
						peak_ff <= nxt_peak;
						if (final_res) begin
							state_ff     <= SEQ_NEXT;
							warn_cnt_ff  <= warn_cnt_ff + CNT_W'(nxt_warn);
							alarm_cnt_ff <= alarm_cnt_ff + CNT_W'(nxt_alarm);
						end else begin
							state_ff <= SEQ_REQ;
							samp_ff  <= samp_ff + 3'h1;
						end
					end
				end
				SEQ_NEXT: begin
					samp_ff <= 3'h0;
					if (last_entry || !run) begin
						state_ff <= SEQ_IDLE;
						port_ff  <= ~port_ff;
					end else begin
						state_ff <= SEQ_REQ;
						idx_ff   <= idx_ff + 5'h01;
					end
				end
			endcase
		end
	end

	// Request strobe is combinational, its fields are registers
	assign meas_req     = (state_ff == SEQ_REQ) && run;
	assign meas_port    = port_ff;
	assign meas_idx     = idx_ff;
	assign meas_digital = cur.digital;

	// ==========================================================
	// Per entry exceedance flags
	// Rewriting an entry drops its history so old limits do not linger
	always_ff @(posedge core_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			warn_act_ff  <= '{default: '0};
			alarm_act_ff <= '{default: '0};
		end else if (cfg_we && cfg_idx < LIST_MAX) begin
			warn_act_ff[cfg_port][cfg_idx]  <= 1'b0;
			alarm_act_ff[cfg_port][cfg_idx] <= 1'b0;
		end else if (final_res) begin
			warn_act_ff[port_ff][idx_ff]  <= nxt_warn;
			alarm_act_ff[port_ff][idx_ff] <= nxt_alarm;
		end
	end

	// ==========================================================
	// Pass statuses
	logic [1:0] alarm_ff;
	logic [1:0] warning_ff;
	logic       pass_end;
	logic       alarm_now;

	assign pass_end  = (state_ff == SEQ_NEXT) && last_entry;
	assign alarm_now = alarm_cnt_ff > tolerance;
	// An aborted pass leaves the previous verdict in place
	always_ff @(posedge core_clk or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			alarm_ff   <= 2'h0;
			warning_ff <= 2'h0;
		end else if (pass_end) begin
			alarm_ff[port_ff]   <= alarm_now;
			warning_ff[port_ff] <= (warn_cnt_ff > tolerance)
			                       && !alarm_now;
		end
	end
	assign ingress_alarm   = alarm_ff;
	assign ingress_warning = warning_ff;

	// ==========================================================
	// Automatic blocking, one controller per input
	for (genvar p = 0; p < NUM_IN; p++) begin : g_blk
		sw_state_t        sw_ff;      // Switch state owned by blocking
		sw_state_t        pend_ff;    // Target being timed
		logic [DLY_W-1:0] cnt_ff;     // Elapsed cycles for target
		sw_state_t        target;     // State the statuses call for
		logic [DLY_W-1:0] dly;        // Delay for the current target
		logic [3:0]       att;        // Validated attenuation
		switch_t          out_ff;     // Registered switch command

		// Map statuses to the state each mode asks for
		always_comb begin
			unique case (auto_ingress_block[p])
				BLK_ALM_ATT: target = alarm_ff[p] ? SW_ATT : SW_0DB;
				BLK_ALM_CUT: target = alarm_ff[p] ? SW_CUT : SW_0DB;
				BLK_COMBO:   target = alarm_ff[p] ? SW_CUT
				                      : (warning_ff[p] ? SW_ATT : SW_0DB);
				BLK_OFF:     target = SW_0DB;
			endcase
		end
		assign dly = (target == SW_0DB) ? deact_delay[p] : act_delay[p];
		// Out of range settings fall back to the default level
		assign att = (atten_cfg[p] < ATT_MIN || atten_cfg[p] > ATT_MAX)
		             ? ATT_DEF : atten_cfg[p];

		// Delay timing; a zero delay acts after one cycle
		always_ff @(posedge core_clk or negedge rst_sync_ff) begin
			if (!rst_sync_ff) begin
				sw_ff   <= SW_0DB;
				pend_ff <= SW_0DB;
				cnt_ff  <= '0;
			end else if (auto_ingress_block[p] == BLK_OFF) begin
				sw_ff   <= SW_0DB;
				pend_ff <= SW_0DB;
				cnt_ff  <= '0;
			end else if (target == sw_ff) begin
				pend_ff <= target;
				cnt_ff  <= '0;
			end else if (target != pend_ff) begin
				pend_ff <= target;
				cnt_ff  <= '0;
			end else if (cnt_ff + 32'h1 >= dly) begin
				sw_ff  <= target;
				cnt_ff <= '0;
			end else begin
				cnt_ff <= cnt_ff + 32'h1;
			end
		end

		// Blocking overrides the user; disabled passes the user through
		always_ff @(posedge core_clk or negedge rst_sync_ff) begin
			if (!rst_sync_ff) begin
				out_ff <= '{state: SW_0DB, atten_db: ATT_DEF};
			end else if (auto_ingress_block[p] == BLK_OFF) begin
				out_ff <= user_switch[p];
			end else begin
				out_ff <= '{state: sw_ff, atten_db: att};
			end
		end
		assign switch_out[p] = out_ff;
	end

endmodule // ingress_monitor

// ### shared/ingress_pkg.sv
// Constants, modes and carriers for ingress supervision and blocking
package ingress_pkg;
	// ==========================================================
	// Sizes
	localparam int         NUM_IN     = 2;       // Return inputs
	localparam int         MAX_FREQ   = 30;      // List entries per input
	localparam int         IDX_W      = 5;       // Entry index width
	localparam int         LVL_W      = 10;      // Level, 0.1 dB per LSB
	localparam int         CNT_W      = 5;       // Exceedance count width
	localparam int         DLY_W      = 32;      // Delay count width
	localparam logic [4:0] LIST_MAX   = 5'h1e;   // 30 entries at most
	// ==========================================================
	// Measurement and hysteresis
	localparam logic [2:0]       PEAK_SAMPLES = 3'h5;  // Analog max hold
	localparam logic [LVL_W-1:0] HYST_LSB     = 10'h00a; // 1 dB in 0.1 dB
	// ==========================================================
	// Attenuation level in dB
	localparam logic [3:0] ATT_DEF = 4'h6;
	localparam logic [3:0] ATT_MIN = 4'h3;
	localparam logic [3:0] ATT_MAX = 4'ha;
	// ==========================================================
	// Blocking modes and switch states
	typedef enum logic [1:0] {
		BLK_OFF     = 2'h0,   // Switch under user control
		BLK_ALM_ATT = 2'h1,   // Alarm attenuates
		BLK_ALM_CUT = 2'h2,   // Alarm cuts off
		BLK_COMBO   = 2'h3    // Warning attenuates, alarm cuts off
	} blk_mode_t;
	typedef enum logic [1:0] {
		SW_0DB = 2'h0,        // Straight through
		SW_ATT = 2'h1,        // Adjustable attenuation
		SW_CUT = 2'h2         // -50 dB cut-off
	} sw_state_t;
	// ==========================================================
	// Carriers
	typedef struct packed {
		logic             digital;    // 1 averaging, 0 peak
		logic             warn_en;    // Warning limit present
		logic [LVL_W-1:0] warn_lim;
		logic             alarm_en;   // Alarm limit present
		logic [LVL_W-1:0] alarm_lim;
	} entry_t;
	typedef struct packed {
		sw_state_t  state;
		logic [3:0] atten_db;
	} switch_t;
endpackage
